/* design/upd_dma_ctrl.sv */
/*
  DMA control section of a full-speed USB peripheral: configuration and
  byte counter registers reached by command codes, the DMA request engine,
  the end-of-transfer pin and the device reset command.
  Assumes the command/data strobes, bus reset, short packet and endpoint
  information come from logic on i_core_clk; DMA pins are asynchronous.
*/
// Behaviour
// - command F0 writes, F1 reads configuration; two data bytes each.
// - USB bus reset clears only the DMA enable bit.
// - count-zero enable raises end-of-transfer when counter reaches zero.
// - short-packet mode raises end-of-transfer on short OUT packet.
// - endpoint index bits 7..4 select the DMA endpoint buffer.
// - writing enable 1 starts DMA; writing 0 stops it at once.
// - enable bit reads back current DMA running state.
// - burst field picks 1, 4, 8 or 16 byte bursts.
// - other configuration fields survive a USB bus reset.
// - command F2 writes, F3 reads the 16-bit counter; write sets count.
// - counter read returns bytes still to move.
// - programmed count survives a USB bus reset.
// - each enable reloads the working counter from the programmed count.
// - counter high byte in bits 15..8, low byte in bits 7..0.
// - command F6 resets the device like the reset input, except the pin synchronisers.
// - IN buffer holds data for host; OUT buffer receives host data.
// - DMA skips the two length bytes, starting at the third byte.
// - external end-of-transfer on IN endpoint sends buffer contents.
// - double-buffered endpoint moves to secondary buffer at primary end.
// - end-of-transfer polarity bit: 0 active low, 1 active high.
`timescale 1ns/10ps
module upd_dma_ctrl (
  // clock, reset, enable
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  // command interface
  input  wire logic       i_cmd_valid,
  input  wire logic [7:0] i_cmd_code,
  input  wire logic       i_data_wr,
  input  wire logic [7:0] i_data_wdata,
  input  wire logic       i_data_rd,
  output logic      [7:0] o_data_rdata,
  output logic            o_data_rvalid,
  output logic            o_dev_reset,
  // usb side status
  input  wire logic       i_usb_bus_reset,
  input  wire logic       i_out_short_pkt,
  input  wire logic       i_ep_dir_out,
  input  wire logic [9:0] i_ep_buf_size,
  input  wire logic       i_ep_double_buf,
  input  wire logic       i_transfer_end_polarity,
  output logic            o_in_commit,
  // endpoint buffer port
  output logic      [3:0] o_dma_endpoint_index,
  output logic            o_buf_bank,
  output logic      [9:0] o_buf_addr,
  output logic            o_buf_we,
  output logic      [7:0] o_buf_wdata,
  input  wire logic [7:0] i_buf_rdata,
  // external dma pins
  output logic            o_dma_req,
  input  wire logic       i_dma_ack,
  input  wire logic [7:0] i_dma_wdata,
  output logic      [7:0] o_dma_rdata,
  input  wire logic       i_transfer_end_signal,
  output logic            o_transfer_end_signal,
  output logic            o_transfer_end_signal_oe
);

  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  upd_pkg::upd_cmd_state_t st_q, st_d;
  logic        sel_cnt_q, sel_cnt_d;
  logic [7:0]  wr_lo_q, wr_lo_d;
  logic [15:0] shadow_q, shadow_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic        sw_reset_q, sw_reset_d;
  logic        cnt_zero_end_enable_q, cnt_zero_end_enable_d;
  logic        short_packet_end_mode_q, short_packet_end_mode_d;
  logic [3:0]  dma_endpoint_index_q, dma_endpoint_index_d;
  logic        dma_transfer_enable_q, dma_transfer_enable_d;
  logic [1:0]  dma_burst_length_q, dma_burst_length_d;
  logic [15:0] dma_count_q, dma_count_d;
  logic [15:0] work_count_q, work_count_d;
  logic [9:0]  ptr_q, ptr_d;
  logic        bank_q, bank_d;
  logic [4:0]  burst_cnt_q, burst_cnt_d;
  logic        gap_q, gap_d;
  logic        req_q, req_d;
  logic        buf_we_q, buf_we_d;
  logic [7:0]  buf_wdata_q, buf_wdata_d;
  logic [7:0]  dma_rdata_q, dma_rdata_d;
  logic        in_commit_q, in_commit_d;
  logic        eot_out_q, eot_out_d;
  logic        eot_oe_q, eot_oe_d;
  logic        dack_prev_q;
  logic [9:0]  sync1_q, sync2_q;
  logic        rst_all;

  // block reset, pin synchronisers excepted: pin reset or the device reset command
  assign rst_all = i_rst | sw_reset_q;

  // -----------------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------------
  // ack, end-of-transfer and dma data pass two flip-flops
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_q     <= 10'h000;
      sync2_q     <= 10'h000;
      dack_prev_q <= 1'b0;
    end else if (i_ce) begin
      sync1_q     <= {i_transfer_end_signal, i_dma_ack, i_dma_wdata};
      sync2_q     <= sync1_q;
      dack_prev_q <= sync2_q[8];
    end
  end

  // -----------------------------------------------------------------------
  // next-state logic
  // -----------------------------------------------------------------------
  // command sequencer, dma engine and end-of-transfer handling
  always_comb begin
    logic        dack_rise;
    logic        ext_end;
    logic [15:0] cfg_word;
    logic [15:0] wr_word;
    logic [4:0]  burst_len;
    logic        stop;
    logic        step;
    dack_rise = sync2_q[8] & ~dack_prev_q;
    // pointer moves after the byte has used it: at the read, or once the write is out
    step      = (dma_transfer_enable_q & dack_rise & i_ep_dir_out) | buf_we_q;
    ext_end   = (sync2_q[9] == i_transfer_end_polarity) & eot_oe_q;
    cfg_word  = 16'h0000;
    cfg_word[upd_pkg::CFG_CNT_ZERO_BIT] = cnt_zero_end_enable_q;
    cfg_word[upd_pkg::CFG_SHORT_BIT]    = short_packet_end_mode_q;
    cfg_word[upd_pkg::CFG_EP_MSB:upd_pkg::CFG_EP_LSB] = dma_endpoint_index_q;
    cfg_word[upd_pkg::CFG_EN_BIT]       = dma_transfer_enable_q;
    cfg_word[upd_pkg::CFG_BURST_MSB:upd_pkg::CFG_BURST_LSB] = dma_burst_length_q;
    wr_word   = {i_data_wdata, wr_lo_q};
    unique case (dma_burst_length_q)
      2'b00: burst_len = upd_pkg::BURST_LEN_00;
      2'b01: burst_len = upd_pkg::BURST_LEN_01;
      2'b10: burst_len = upd_pkg::BURST_LEN_10;
      2'b11: burst_len = upd_pkg::BURST_LEN_11;
    endcase
    stop = 1'b0;
    st_d = st_q;
    sel_cnt_d = sel_cnt_q;
    wr_lo_d = wr_lo_q;
    shadow_d = shadow_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    sw_reset_d = 1'b0;
    cnt_zero_end_enable_d = cnt_zero_end_enable_q;
    short_packet_end_mode_d = short_packet_end_mode_q;
    dma_endpoint_index_d = dma_endpoint_index_q;
    dma_transfer_enable_d = dma_transfer_enable_q;
    dma_burst_length_d = dma_burst_length_q;
    dma_count_d = dma_count_q;
    work_count_d = work_count_q;
    ptr_d = ptr_q;
    bank_d = bank_q;
    burst_cnt_d = burst_cnt_q;
    gap_d = 1'b0;
    buf_we_d = 1'b0;
    buf_wdata_d = buf_wdata_q;
    dma_rdata_d = dma_rdata_q;
    in_commit_d = 1'b0;

    // byte moves on each rising ack edge while dma runs
    if (dma_transfer_enable_q && dack_rise) begin
      if (i_ep_dir_out) begin
        dma_rdata_d = i_buf_rdata;                       // OUT data to host memory
      end else begin
        buf_we_d    = 1'b1;                              // IN data for the host
        buf_wdata_d = sync2_q[7:0];
      end
      if (work_count_q != 16'h0000) begin
        work_count_d = work_count_q - 16'h0001;
      end
      if (burst_cnt_q + 5'h01 == burst_len) begin
        burst_cnt_d = 5'h00;
        gap_d       = 1'b1;                              // drop request between bursts
      end else begin
        burst_cnt_d = burst_cnt_q + 5'h01;
      end
    end

    // buffer pointer step, so a write lands on the address shown with it
    if (step) begin
      if (ptr_q == i_ep_buf_size + 10'h001) begin
        ptr_d = upd_pkg::BUF_DATA_START;
        if (i_ep_double_buf) begin
          bank_d = ~bank_q;
        end
      end else begin
        ptr_d = ptr_q + 10'h001;
      end
    end

    // end-of-transfer sources
    if (dma_transfer_enable_q && cnt_zero_end_enable_q && work_count_q == 16'h0000) begin
      stop = 1'b1;
    end
    if (dma_transfer_enable_q && short_packet_end_mode_q && i_ep_dir_out
        && i_out_short_pkt) begin
      stop = 1'b1;
    end
    if (stop) begin
      dma_transfer_enable_d = 1'b0;
    end
    if (dma_transfer_enable_q && ext_end) begin
      dma_transfer_enable_d = 1'b0;
      in_commit_d = ~i_ep_dir_out;
    end

    // command sequencer
    if (i_cmd_valid) begin
      unique case (i_cmd_code)
        upd_pkg::CMD_CFG_WR: begin
          st_d = upd_pkg::CMD_WR_LO;
          sel_cnt_d = 1'b0;
        end
        upd_pkg::CMD_CNT_WR: begin
          st_d = upd_pkg::CMD_WR_LO;
          sel_cnt_d = 1'b1;
        end
        upd_pkg::CMD_CFG_RD: begin
          st_d = upd_pkg::CMD_RD_LO;
          shadow_d = cfg_word;
        end
        upd_pkg::CMD_CNT_RD: begin
          st_d = upd_pkg::CMD_RD_LO;
          shadow_d = work_count_q;
        end
        upd_pkg::CMD_DEV_RESET: begin
          st_d = upd_pkg::CMD_IDLE;
          sw_reset_d = 1'b1;
        end
        default: begin
          st_d = upd_pkg::CMD_IDLE;
        end
      endcase
    end else if (i_data_wr) begin
      if (st_q == upd_pkg::CMD_WR_LO) begin
        wr_lo_d = i_data_wdata;
        st_d = upd_pkg::CMD_WR_HI;
      end else if (st_q == upd_pkg::CMD_WR_HI) begin
        st_d = upd_pkg::CMD_IDLE;
        if (sel_cnt_q) begin
          dma_count_d = wr_word;
        end else begin
          cnt_zero_end_enable_d   = wr_word[upd_pkg::CFG_CNT_ZERO_BIT];
          short_packet_end_mode_d = wr_word[upd_pkg::CFG_SHORT_BIT];
          dma_endpoint_index_d    = wr_word[upd_pkg::CFG_EP_MSB:upd_pkg::CFG_EP_LSB];
          dma_burst_length_d      = wr_word[upd_pkg::CFG_BURST_MSB:upd_pkg::CFG_BURST_LSB];
          if (!wr_word[upd_pkg::CFG_EN_BIT]) begin
            dma_transfer_enable_d = 1'b0;
          end else if (!dma_transfer_enable_q) begin
            dma_transfer_enable_d = 1'b1;
            work_count_d = dma_count_q;
            ptr_d        = upd_pkg::BUF_DATA_START;
            bank_d       = 1'b0;
            burst_cnt_d  = 5'h00;
          end
        end
      end
    end else if (i_data_rd) begin
      if (st_q == upd_pkg::CMD_RD_LO) begin
        rdata_d  = shadow_q[7:0];
        rvalid_d = 1'b1;
        st_d     = upd_pkg::CMD_RD_HI;
      end else if (st_q == upd_pkg::CMD_RD_HI) begin
        rdata_d  = shadow_q[15:8];
        rvalid_d = 1'b1;
        st_d     = upd_pkg::CMD_IDLE;
      end
    end

    // bus reset stops dma and leaves every other field alone
    if (i_usb_bus_reset) begin
      dma_transfer_enable_d = 1'b0;
    end

    req_d     = dma_transfer_enable_d & ~gap_d & ~gap_q
                & (work_count_d != 16'h0000 | ~cnt_zero_end_enable_d);
    eot_oe_d  = ~stop;                                   // oe low while driving
    eot_out_d = stop ? i_transfer_end_polarity : ~i_transfer_end_polarity;
  end

  // -----------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------
  // all block state but the pin synchronisers, cleared by either reset source
  always_ff @(posedge i_core_clk) begin
    if (rst_all) begin
      st_q <= upd_pkg::CMD_IDLE;
      sel_cnt_q <= 1'b0;
      wr_lo_q <= 8'h00;
      shadow_q <= 16'h0000;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
      sw_reset_q <= 1'b0;
      cnt_zero_end_enable_q <= upd_pkg::CFG_RESET[upd_pkg::CFG_CNT_ZERO_BIT];
      short_packet_end_mode_q <= upd_pkg::CFG_RESET[upd_pkg::CFG_SHORT_BIT];
      dma_endpoint_index_q <= upd_pkg::CFG_RESET[upd_pkg::CFG_EP_MSB:upd_pkg::CFG_EP_LSB];
      dma_transfer_enable_q <= upd_pkg::CFG_RESET[upd_pkg::CFG_EN_BIT];
      dma_burst_length_q <= upd_pkg::CFG_RESET[upd_pkg::CFG_BURST_MSB:upd_pkg::CFG_BURST_LSB];
      dma_count_q <= upd_pkg::COUNT_RESET;
      work_count_q <= upd_pkg::COUNT_RESET;
      ptr_q <= upd_pkg::BUF_DATA_START;
      bank_q <= 1'b0;
      burst_cnt_q <= 5'h00;
      gap_q <= 1'b0;
      req_q <= 1'b0;
      buf_we_q <= 1'b0;
      buf_wdata_q <= 8'h00;
      dma_rdata_q <= 8'h00;
      in_commit_q <= 1'b0;
      eot_out_q <= 1'b1;
      eot_oe_q <= 1'b1;
    end else if (i_ce) begin
      st_q <= st_d;
      sel_cnt_q <= sel_cnt_d;
      wr_lo_q <= wr_lo_d;
      shadow_q <= shadow_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
      sw_reset_q <= sw_reset_d;
      cnt_zero_end_enable_q <= cnt_zero_end_enable_d;
      short_packet_end_mode_q <= short_packet_end_mode_d;
      dma_endpoint_index_q <= dma_endpoint_index_d;
      dma_transfer_enable_q <= dma_transfer_enable_d;
      dma_burst_length_q <= dma_burst_length_d;
      dma_count_q <= dma_count_d;
      work_count_q <= work_count_d;
      ptr_q <= ptr_d;
      bank_q <= bank_d;
      burst_cnt_q <= burst_cnt_d;
      gap_q <= gap_d;
      req_q <= req_d;
      buf_we_q <= buf_we_d;
      buf_wdata_q <= buf_wdata_d;
      dma_rdata_q <= dma_rdata_d;
      in_commit_q <= in_commit_d;
      eot_out_q <= eot_out_d;
      eot_oe_q <= eot_oe_d;
    end
  end

  // -----------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------
  // every output is a flip-flop
  assign o_data_rdata = rdata_q;
  assign o_data_rvalid = rvalid_q;
  assign o_dev_reset = sw_reset_q;
  assign o_in_commit = in_commit_q;
  assign o_dma_endpoint_index = dma_endpoint_index_q;
  assign o_buf_bank = bank_q;
  assign o_buf_addr = ptr_q;
  assign o_buf_we = buf_we_q;
  assign o_buf_wdata = buf_wdata_q;
  assign o_dma_req = req_q;
  assign o_dma_rdata = dma_rdata_q;
  assign o_transfer_end_signal = eot_out_q;
  assign o_transfer_end_signal_oe = eot_oe_q;

endmodule

/* design/upd_pkg.sv */
/*
  Shared constants for the USB peripheral DMA control block: command codes,
  register field positions, reset values and the command sequencer states.
  Assumes nothing of its surroundings; included by name where needed.
*/
package upd_pkg;

  // ---------------------------------------------------------------------
  // command codes of the parallel microcontroller interface
  // ---------------------------------------------------------------------
  localparam logic [7:0] CMD_CFG_WR     = 8'hF0;
  localparam logic [7:0] CMD_CFG_RD     = 8'hF1;
  localparam logic [7:0] CMD_CNT_WR     = 8'hF2;
  localparam logic [7:0] CMD_CNT_RD     = 8'hF3;
  localparam logic [7:0] CMD_DEV_RESET  = 8'hF6;

  // ---------------------------------------------------------------------
  // dma_configuration field positions
  // ---------------------------------------------------------------------
  localparam int CFG_CNT_ZERO_BIT = 15;
  localparam int CFG_SHORT_BIT    = 14;
  localparam int CFG_EP_MSB       = 7;
  localparam int CFG_EP_LSB       = 4;
  localparam int CFG_EN_BIT       = 3;
  localparam int CFG_BURST_MSB    = 1;
  localparam int CFG_BURST_LSB    = 0;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [15:0] CFG_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ---------------------------------------------------------------------
  // endpoint buffer layout: two length bytes precede the data
  // ---------------------------------------------------------------------
  localparam logic [9:0] BUF_DATA_START = 10'h002;

  // ---------------------------------------------------------------------
  // burst length encodings, in bytes
  // ---------------------------------------------------------------------
  localparam logic [4:0] BURST_LEN_00 = 5'h01;
  localparam logic [4:0] BURST_LEN_01 = 5'h04;
  localparam logic [4:0] BURST_LEN_10 = 5'h08;
  localparam logic [4:0] BURST_LEN_11 = 5'h10;

  // command sequencer states
  typedef enum logic [2:0] {
    CMD_IDLE,
    CMD_WR_LO,
    CMD_WR_HI,
    CMD_RD_LO,
    CMD_RD_HI
  } upd_cmd_state_t;

endpackage

/* test/tb_top.sv */
/*
  Self-checking bench for upd_dma_ctrl with the dma controller model.
  Assumes the checker is bound to the design.
*/
`timescale 1ns/10ps
module tb_top;
  logic i_core_clk = 0, i_rst = 1, i_ce = 1, i_cmd_valid = 0, i_data_wr = 0, i_data_rd = 0;
  logic [7:0] i_cmd_code = 8'h00, i_data_wdata = 8'h00;
  logic i_usb_bus_reset = 0, i_out_short_pkt = 0, i_ep_dir_out = 0, i_ep_double_buf = 1;
  logic pol = 0, ext_end = 1, pause = 1, slow = 0, burst_chk = 0, exp_bank = 0;
  logic prev_ack = 0, prev_req = 0, o_data_rvalid, o_dev_reset, o_in_commit, o_buf_bank;
  logic o_buf_we, o_dma_req, dma_ack, o_end, o_end_oe, end_line;
  logic [9:0] i_ep_buf_size = 10'h006, o_buf_addr, exp_ptr = 10'h002;
  logic [7:0] o_data_rdata, o_dma_rdata, o_buf_wdata, dma_wdata, host_last, buf_rdata;
  logic [3:0] o_dma_endpoint_index;
  logic [15:0] cfgv;
  int mismatches = 0, checks_done = 0, acks_ep = 0, acks_total = 0, exp_len = 1;
  int lens[4] = '{1, 4, 8, 16};
  logic [7:0] exp_q[$];

  // end line resolves to the design while it drives, else to the bench
  assign end_line = o_end_oe ? ext_end : o_end;
  assign buf_rdata = o_buf_addr[7:0] ^ 8'h3C;
  always #2 i_core_clk = ~i_core_clk;

  upd_dma_ctrl upd_dma_ctrl_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .i_data_wr(i_data_wr),
    .i_data_wdata(i_data_wdata), .i_data_rd(i_data_rd), .o_data_rdata(o_data_rdata),
    .o_data_rvalid(o_data_rvalid), .o_dev_reset(o_dev_reset), .i_usb_bus_reset(i_usb_bus_reset),
    .i_out_short_pkt(i_out_short_pkt), .i_ep_dir_out(i_ep_dir_out), .i_ep_buf_size(i_ep_buf_size),
    .i_ep_double_buf(i_ep_double_buf), .i_transfer_end_polarity(pol), .o_in_commit(o_in_commit),
    .o_dma_endpoint_index(o_dma_endpoint_index), .o_buf_bank(o_buf_bank), .o_buf_addr(o_buf_addr),
    .o_buf_we(o_buf_we), .o_buf_wdata(o_buf_wdata), .i_buf_rdata(buf_rdata),
    .o_dma_req(o_dma_req), .i_dma_ack(dma_ack), .i_dma_wdata(dma_wdata),
    .o_dma_rdata(o_dma_rdata), .i_transfer_end_signal(end_line), .o_transfer_end_signal(o_end),
    .o_transfer_end_signal_oe(o_end_oe));
  upd_host_model upd_host_model_inst (.i_clk(i_core_clk), .i_req(o_dma_req), .i_pause(pause),
    .i_slow(slow), .o_ack(dma_ack), .o_wdata(dma_wdata), .o_last(host_last));

  task automatic tick; @(posedge i_core_clk); #1; endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // command phase then two bytes, low byte first
  task automatic wr16(input logic [7:0] c, input logic [15:0] v);
    tick; i_cmd_valid = 1; i_cmd_code = c;
    tick; i_cmd_valid = 0; i_data_wr = 1; i_data_wdata = v[7:0];
    tick; i_data_wdata = v[15:8];
    tick; i_data_wr = 0;
    repeat (2) tick;
  endtask
  task automatic rd16(input logic [7:0] c, input logic [15:0] v);
    exp_q.push_back(v[7:0]);
    exp_q.push_back(v[15:8]);
    tick; i_cmd_valid = 1; i_cmd_code = c;
    tick; i_cmd_valid = 0; i_data_rd = 1;
    tick; i_data_rd = 0;
    tick; i_data_rd = 1;
    tick; i_data_rd = 0;
    repeat (2) tick;
  endtask
  task automatic dev_reset;
    tick; i_cmd_valid = 1; i_cmd_code = 8'hF6;
    tick; i_cmd_valid = 0;
    check({15'h0000, o_dev_reset}, 16'h0001);
    repeat (3) tick;
    exp_ptr = 10'h002;
    exp_bank = 0;
  endtask
  // bounded wait: 0 end pin, 1 commit, 2 five acks
  task automatic wait_for(input int sel);
    int i;
    for (i = 0; i < 2000; i++) begin
      tick;
      if (sel == 0 ? o_end_oe === 1'b0 : sel == 1 ? o_in_commit === 1'b1 : acks_total >= 5)
        break;
    end
    if (i == 2000) begin
      mismatches++;
      $display("Error at %0t: wait ran out, seen %h expected %h", $time, 1'b0, 1'b1);
      finish_test;
    end
  endtask

  // output watcher: read bytes, buffer writes, ack counts per burst
  always @(negedge i_core_clk) begin
    if (o_data_rvalid === 1'b1) begin
      if (exp_q.size() == 0) check(16'h0001, 16'h0000);
      else check({8'h00, o_data_rdata}, {8'h00, exp_q.pop_front()});
    end
    if (o_buf_we === 1'b1) begin
      check({6'h00, o_buf_addr}, {6'h00, exp_ptr});
      check({15'h0000, o_buf_bank}, {15'h0000, exp_bank});
      check({8'h00, o_buf_wdata}, {8'h00, host_last});
      if (exp_ptr == i_ep_buf_size + 10'h001) exp_bank = exp_bank ^ i_ep_double_buf;
      exp_ptr = (exp_ptr == i_ep_buf_size + 10'h001) ? 10'h002 : exp_ptr + 10'h001;
    end
    if (dma_ack && !prev_ack) begin acks_ep++; acks_total++; end
    if (prev_req && o_dma_req === 1'b0 && burst_chk) begin
      check(16'(acks_ep), 16'(exp_len));
      acks_ep = 0;
    end
    prev_ack = dma_ack;
    prev_req = o_dma_req;
  end

  initial begin
    void'($urandom(32'hD6E6));
    repeat (8) tick;
    i_rst = 0;
    rd16(8'hF1, 16'h0000);
    rd16(8'hF3, 16'h0000);
    check({6'h00, o_buf_addr}, 16'h0002);
    cfgv = 16'($urandom) & 16'hFFF7;
    wr16(8'hF0, cfgv);
    rd16(8'hF1, cfgv & 16'hC0F3);
    check({12'h000, o_dma_endpoint_index}, {12'h000, cfgv[7:4]});
    // every burst length, counted to zero
    for (int b = 0; b < 4; b++) begin
      dev_reset;
      rd16(8'hF1, 16'h0000);
      pol = 1'($urandom);
      ext_end = ~pol;
      pause = 0;
      wr16(8'hF2, 16'h0010);
      exp_len = lens[b];
      acks_ep = 0;
      burst_chk = 1;
      cfgv = 16'h8008 | 16'(b) | (16'($urandom) & 16'h00F0);
      wr16(8'hF0, cfgv);
      wait_for(0);
      check({15'h0000, o_end}, {15'h0000, pol});
      repeat (4) tick;
      burst_chk = 0;
      pause = 1;
      rd16(8'hF3, 16'h0000);
      rd16(8'hF1, cfgv & 16'hFFF7);
    end
    // stop mid transfer, reload, bus reset
    dev_reset;
    i_ep_dir_out = 1;
    slow = 1;
    pause = 0;
    wr16(8'hF2, 16'h0028);
    acks_total = 0;
    wr16(8'hF0, 16'h0058);
    wait_for(2);
    pause = 1;
    repeat (20) tick;
    check({8'h00, o_dma_rdata}, {8'h00, (8'h01 + 8'(acks_total)) ^ 8'h3C});
    rd16(8'hF3, 16'h0028 - 16'(acks_total));
    wr16(8'hF0, 16'h0050);
    repeat (2) tick;
    check({15'h0000, o_dma_req}, 16'h0000);
    rd16(8'hF1, 16'h0050);
    wr16(8'hF0, 16'h0058);
    rd16(8'hF3, 16'h0028);
    tick; i_usb_bus_reset = 1;
    tick; i_usb_bus_reset = 0;
    repeat (2) tick;
    rd16(8'hF1, 16'h0050);
    wr16(8'hF0, 16'h0058);
    rd16(8'hF3, 16'h0028);
    // short packet ends the transfer
    wr16(8'hF0, 16'h4058);
    tick; i_out_short_pkt = 1;
    tick; i_out_short_pkt = 0;
    check({15'h0000, o_end_oe}, 16'h0000);
    rd16(8'hF1, 16'h4050);
    // external end on an in endpoint
    dev_reset;
    i_ep_dir_out = 0;
    slow = 0;
    i_ep_double_buf = 0;
    pol = 1;
    ext_end = 0;
    wr16(8'hF2, 16'h0064);
    wr16(8'hF0, 16'h0008);
    pause = 0;
    repeat (90) tick;
    ext_end = 1;
    wait_for(1);
    ext_end = 0;
    pause = 1;
    repeat (12) tick;
    rd16(8'hF1, 16'h0000);
    finish_test;
  end
endmodule

/* test/upd_dma_ctrl_assertions.sv */
/*
  Port checker for upd_dma_ctrl: read answers, device reset, bus reset,
  buffer pointer and end pin timing.
  Assumes it is bound onto every upd_dma_ctrl instance.
*/
`timescale 1ns/10ps
module upd_chk (
  // clock and reset
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  // command side
  input wire logic       i_ce,
  input wire logic       i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic       i_data_rd,
  input wire logic       o_data_rvalid,
  input wire logic       o_dev_reset,
  // usb and dma side
  input wire logic       i_usb_bus_reset,
  input wire logic       i_ep_dir_out,
  input wire logic       i_transfer_end_polarity,
  input wire logic       o_in_commit,
  input wire logic [3:0] o_dma_endpoint_index,
  input wire logic [9:0] o_buf_addr,
  input wire logic       o_buf_we,
  input wire logic       o_dma_req,
  input wire logic       o_transfer_end_signal,
  input wire logic       o_transfer_end_signal_oe
);
  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  a_rd_answer: assert property (o_data_rvalid |-> $past(i_data_rd))
    else $error("read byte without request");
  a_dev_reset: assert property (
    i_ce && i_cmd_valid && i_cmd_code == upd_pkg::CMD_DEV_RESET |-> ##[1:2] o_dev_reset)
    else $error("device reset command not obeyed");
  a_reset_values: assert property (
    o_dev_reset |-> ##[1:2] (o_buf_addr == 10'h002
    && !o_dma_req && o_dma_endpoint_index == 4'h0 && o_transfer_end_signal_oe))
    else $error("state not cleared by device reset");
  a_bus_rst_stop: assert property (i_ce && i_usb_bus_reset |-> ##[1:3] !o_dma_req)
    else $error("dma still requested after bus reset");
  a_bus_rst_keep: assert property (i_ce && i_usb_bus_reset
    |=> $stable(o_dma_endpoint_index))
    else $error("endpoint index lost on bus reset");
  a_buf_floor: assert property (o_buf_addr >= 10'h002)
    else $error("pointer inside length bytes");
  a_end_level: assert property (!o_transfer_end_signal_oe
    |-> o_transfer_end_signal == i_transfer_end_polarity)
    else $error("end pin driven at wrong level");
  a_end_pulse: assert property (!o_transfer_end_signal_oe |=> o_transfer_end_signal_oe)
    else $error("end pin driven longer than one cycle");
  a_end_stop: assert property (!o_transfer_end_signal_oe |-> ##[0:3] !o_dma_req)
    else $error("dma request survives end of transfer");
  a_commit_dir: assert property (o_in_commit |-> !i_ep_dir_out)
    else $error("commit on an out endpoint");
  a_buf_we_dir: assert property (o_buf_we |-> !i_ep_dir_out)
    else $error("buffer written for an out endpoint");

  // main scenarios reached
  c_dev_reset: cover property (o_dev_reset);
  c_end_pin: cover property (!o_transfer_end_signal_oe);
  c_commit: cover property (o_in_commit);
  c_buf_we: cover property (o_buf_we);
endmodule

bind upd_dma_ctrl upd_chk upd_chk_inst (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cmd_valid(i_cmd_valid),
  .i_cmd_code(i_cmd_code), .i_data_rd(i_data_rd), .o_data_rvalid(o_data_rvalid),
  .o_dev_reset(o_dev_reset), .i_usb_bus_reset(i_usb_bus_reset), .i_ep_dir_out(i_ep_dir_out),
  .i_transfer_end_polarity(i_transfer_end_polarity), .o_in_commit(o_in_commit),
  .o_dma_endpoint_index(o_dma_endpoint_index), .o_buf_addr(o_buf_addr),
  .o_buf_we(o_buf_we), .o_dma_req(o_dma_req), .o_transfer_end_signal(o_transfer_end_signal),
  .o_transfer_end_signal_oe(o_transfer_end_signal_oe));

/* test/upd_host_model.sv */
/*
  Model of the external dma controller: answers requests with acks.
  Assumes the same clock as the block; pause and slow come from the bench.
*/
`timescale 1ns/10ps
module upd_host_model (
  // clock and control
  input  wire logic       i_clk,
  input  wire logic       i_req,
  input  wire logic       i_pause,
  input  wire logic       i_slow,
  // dma pins
  output logic            o_ack,
  output logic      [7:0] o_wdata,
  output logic      [7:0] o_last
);
  initial begin
    o_ack = 1'b0;
    o_wdata = 8'hA5;
    o_last = 8'h5A;
  end

  // one byte per ack, each level held at least four clocks
  always begin
    @(posedge i_clk);
    if (i_req === 1'b1 && i_pause === 1'b0) begin
      #1;
      o_last = 8'($urandom);
      o_wdata = o_last;
      o_ack = 1'b1;
      repeat (5) @(posedge i_clk);
      #1;
      o_ack = 1'b0;
      o_wdata = ~o_last; // released line no longer shows the byte
      repeat (i_slow ? 12 : 4) @(posedge i_clk);
    end
  end
endmodule
